// File: hw/pakr_pkg.sv
// package: encodings, privilege levels and carriers for the key register bank
package pakr_pkg;
    localparam int KEY_W = 64;
    localparam int NUM_KEYS = 5;
    localparam logic [1:0] OP0_SYS = 2'h3;
    localparam logic [2:0] OP1_KEY = 3'h0;
    localparam logic [3:0] CRN_KEY = 4'h2;
    localparam logic [3:0] CRM_INSTR = 4'h1;
    localparam logic [3:0] CRM_DATA = 4'h2;
    localparam logic [3:0] CRM_GEN = 4'h3;
    localparam logic [2:0] OP2_LOW_A = 3'h0;
    localparam logic [2:0] OP2_HIGH_A = 3'h1;
    localparam logic [2:0] OP2_LOW_B = 3'h2;
    localparam logic [2:0] OP2_HIGH_B = 3'h3;
    localparam logic [2:0] IDX_DB_HI = 3'h0;
    localparam logic [2:0] IDX_DB_LO = 3'h1;
    localparam logic [2:0] IDX_GA_HI = 3'h2;
    localparam logic [2:0] IDX_GA_LO = 3'h3;
    localparam logic [2:0] IDX_IA_HI = 3'h4;
    localparam logic [63:0] KEY_RESET = 64'h0;

    typedef enum logic [1:0] {
        PAKR_LVL_APP = 2'h0,
        PAKR_LVL_OS = 2'h1,
        PAKR_LVL_HYP = 2'h2,
        PAKR_LVL_MON = 2'h3
    } pakr_level_t;

    typedef struct packed {
        logic [1:0] op0;
        logic [2:0] op1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] op2;
    } pakr_enc_t;

    typedef struct packed {
        logic valid;
        logic write;
        pakr_level_t level;
        pakr_enc_t enc;
        logic [63:0] wdata;
    } pakr_req_t;

    typedef struct packed {
        logic done;
        logic undef;
        logic denied;
        logic hit;
        logic [63:0] rdata;
    } pakr_rsp_t;
endpackage

// File: hw/pakr_key_regs.sv
// pointer authentication key register bank reached by system register moves
`timescale 1ns/1ps
// Functional notes
// - each key register is 64 bits, one half of a 128-bit key.
// - key contents after reset carry no guarantee; software writes keys first.
// - without the extension built in, any key access is an undefined instruction.
// - move-to writes a key register and move-from returns its content.
// - data key B high decodes at 11/000/0010/0010/011.
// - data key B low decodes at 11/000/0010/0010/010.
// - generic key A high decodes at 11/000/0010/0011/001.
// - generic key A low decodes at 11/000/0010/0011/000.
// - instruction key A high decodes at 11/000/0010/0001/001.
// - application level is denied; os and secure monitor levels may read and write.
// - with the hypervisor level present it may read and write too.
module pakr_key_regs #(
    parameter bit HAS_PAUTH = 1'b1,
    parameter bit HAS_HYP = 1'b1
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic REQ_VALID_I,
    input wire logic REQ_WRITE_I,
    input wire logic [1:0] REQ_LEVEL_I,
    input wire logic [15:0] REQ_ENC_I,
    input wire logic [63:0] REQ_WDATA_I,
    output logic RSP_DONE_O,
    output logic RSP_HIT_O,
    output logic RSP_UNDEF_O,
    output logic RSP_DENIED_O,
    output logic [63:0] RSP_RDATA_O
);
    typedef struct packed {
        logic [pakr_pkg::NUM_KEYS-1:0][63:0] key;
        pakr_pkg::pakr_rsp_t rsp;
    } pakr_state_t;

    localparam logic [2:0] IDX_MISS = 3'h7;

    // the ports and the miss code fix the bank at five 64-bit keys
    if (pakr_pkg::KEY_W != 64) begin : g_bad_width
        $error("key width must be 64");
    end
    if (pakr_pkg::NUM_KEYS != 5) begin : g_bad_count
        $error("key count must be 5");
    end

    pakr_state_t state_reg;
    pakr_state_t state_next;
    pakr_pkg::pakr_req_t req;

    // the request pins travel on as one carrier
    function automatic pakr_pkg::pakr_req_t unpack_req(
        input logic valid,
        input logic write,
        input logic [1:0] level,
        input logic [15:0] enc,
        input logic [63:0] wdata
    );
        pakr_pkg::pakr_req_t r;
        r.valid = valid;
        r.write = write;
        r.level = pakr_pkg::pakr_level_t'(level);
        r.enc = pakr_pkg::pakr_enc_t'(enc);
        r.wdata = wdata;
        return r;
    endfunction

    // every key of this bank sits under one op0/op1/CRn prefix
    function automatic logic prefix_ok(input pakr_pkg::pakr_enc_t e);
        logic ok;
        ok = (e.op0 == pakr_pkg::OP0_SYS);
        ok = ok && (e.op1 == pakr_pkg::OP1_KEY);
        ok = ok && (e.crn == pakr_pkg::CRN_KEY);
        return ok;
    endfunction

    // returns index of the addressed key, or the miss code when the encoding misses
    // instruction key A low and both instruction B keys live elsewhere and fall through as misses
    function automatic logic [2:0] decode_key(input pakr_pkg::pakr_enc_t e);
        logic [2:0] idx;
        idx = IDX_MISS;
        if (prefix_ok(e)) begin
            if (e.crm == pakr_pkg::CRM_DATA && e.op2 == pakr_pkg::OP2_HIGH_B) begin
                idx = pakr_pkg::IDX_DB_HI;
            end
            if (e.crm == pakr_pkg::CRM_DATA && e.op2 == pakr_pkg::OP2_LOW_B) begin
                idx = pakr_pkg::IDX_DB_LO;
            end
            if (e.crm == pakr_pkg::CRM_GEN && e.op2 == pakr_pkg::OP2_HIGH_A) begin
                idx = pakr_pkg::IDX_GA_HI;
            end
            if (e.crm == pakr_pkg::CRM_GEN && e.op2 == pakr_pkg::OP2_LOW_A) begin
                idx = pakr_pkg::IDX_GA_LO;
            end
            if (e.crm == pakr_pkg::CRM_INSTR && e.op2 == pakr_pkg::OP2_HIGH_A) begin
                idx = pakr_pkg::IDX_IA_HI;
            end
        end
        return idx;
    endfunction

    // access table by privilege level
    function automatic logic level_ok(input pakr_pkg::pakr_level_t lvl);
        logic ok;
        ok = 1'h0;
        unique case (lvl)
            pakr_pkg::PAKR_LVL_APP: begin
                ok = 1'h0;
            end
            pakr_pkg::PAKR_LVL_OS: begin
                ok = 1'h1;
            end
            pakr_pkg::PAKR_LVL_HYP: begin
                ok = HAS_HYP;
            end
            pakr_pkg::PAKR_LVL_MON: begin
                ok = 1'h1;
            end
        endcase
        return ok;
    endfunction

    // one-hot select of the addressed key, empty on a miss
    function automatic logic [pakr_pkg::NUM_KEYS-1:0] key_select(input logic [2:0] idx);
        logic [pakr_pkg::NUM_KEYS-1:0] sel;
        sel = '0;
        for (int k = 0; k < pakr_pkg::NUM_KEYS; k++) begin
            if (idx == 3'(k)) begin
                sel[k] = 1'h1;
            end
        end
        return sel;
    endfunction

    // and-or read mux: a miss can never index past the array, and unread keys stay masked
    function automatic logic [63:0] key_read(
        input logic [pakr_pkg::NUM_KEYS-1:0][63:0] keys,
        input logic [pakr_pkg::NUM_KEYS-1:0] sel
    );
        logic [63:0] val;
        val = '0;
        for (int k = 0; k < pakr_pkg::NUM_KEYS; k++) begin
            val = val | (keys[k] & {64{sel[k]}});
        end
        return val;
    endfunction

    // write port: only the selected key takes the new word
    function automatic logic [pakr_pkg::NUM_KEYS-1:0][63:0] next_keys(
        input logic [pakr_pkg::NUM_KEYS-1:0][63:0] keys,
        input logic [pakr_pkg::NUM_KEYS-1:0] wr_en,
        input logic [63:0] wdata
    );
        logic [pakr_pkg::NUM_KEYS-1:0][63:0] nk;
        nk = keys;
        for (int k = 0; k < pakr_pkg::NUM_KEYS; k++) begin
            if (wr_en[k]) begin
                nk[k] = wdata;
            end
        end
        return nk;
    endfunction

    // outcome of one access: undefined beats denied beats performed
    // without the extension the encodings are simply unallocated, so the level is not asked
    function automatic pakr_pkg::pakr_rsp_t classify(
        input logic valid,
        input logic hit,
        input logic ok
    );
        pakr_pkg::pakr_rsp_t r;
        r = '0;
        r.done = valid;
        if (valid && hit) begin
            if (!HAS_PAUTH) begin
                r.undef = 1'h1;
            end else if (!ok) begin
                r.denied = 1'h1;
            end else begin
                r.hit = 1'h1;
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [2:0] idx;
        logic [pakr_pkg::NUM_KEYS-1:0] sel;
        logic [pakr_pkg::NUM_KEYS-1:0] wr_en;
        pakr_pkg::pakr_rsp_t rsp;
        idx = IDX_MISS;
        sel = '0;
        wr_en = '0;
        rsp = '0;
        req = unpack_req(REQ_VALID_I, REQ_WRITE_I, REQ_LEVEL_I, REQ_ENC_I, REQ_WDATA_I);
        idx = decode_key(req.enc);
        sel = key_select(idx);
        rsp = classify(req.valid, |sel, level_ok(req.level));
        if (rsp.hit && req.write) begin
            wr_en = sel;
        end
        if (rsp.hit && !req.write) begin
            rsp.rdata = key_read(state_reg.key, sel);
        end
        state_next.key = next_keys(state_reg.key, wr_en, req.wdata);
        state_next.rsp = rsp;
    end

    // keys are left out of reset on purpose: no value is promised and it saves reset fanout
    // a request seen while reset is held is not taken, so keys hold still then
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            state_reg.rsp <= '0;
        end else begin
            state_reg.key <= state_next.key;
            state_reg.rsp <= state_next.rsp;
        end
    end

    assign RSP_DONE_O = state_reg.rsp.done;
    assign RSP_HIT_O = state_reg.rsp.hit;
    assign RSP_UNDEF_O = state_reg.rsp.undef;
    assign RSP_DENIED_O = state_reg.rsp.denied;
    assign RSP_RDATA_O = state_reg.rsp.rdata;
endmodule

// File: sim/pakr_key_regs_sva.sv
// checker: response timing, decode and access level properties of the key bank
`timescale 1ns/1ps
module pakr_key_regs_sva #(
    parameter bit HAS_PAUTH = 1'b1,
    parameter bit HAS_HYP = 1'b1
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic REQ_VALID_I,
    input wire logic REQ_WRITE_I,
    input wire logic [1:0] REQ_LEVEL_I,
    input wire logic [15:0] REQ_ENC_I,
    input wire logic [63:0] REQ_WDATA_I,
    input wire logic RSP_DONE_O,
    input wire logic RSP_HIT_O,
    input wire logic RSP_UNDEF_O,
    input wire logic RSP_DENIED_O,
    input wire logic [63:0] RSP_RDATA_O
);
    logic key;
    logic acc;
    assign key = REQ_ENC_I inside {16'hC113, 16'hC112, 16'hC119, 16'hC118, 16'hC109};
    assign acc = REQ_VALID_I && key && HAS_PAUTH;
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_wr;
        acc && REQ_WRITE_I && REQ_LEVEL_I == 2'h1;
    endsequence
    sequence s_rd;
        acc && !REQ_WRITE_I && REQ_LEVEL_I == 2'h3 && REQ_ENC_I == $past(REQ_ENC_I);
    endsequence
    AST_DONE: assert property (REQ_VALID_I |=> RSP_DONE_O)
        else $error("no done after request");
    AST_QUIET: assert property (!REQ_VALID_I |=> !RSP_DONE_O && !RSP_HIT_O)
        else $error("response without request");
    AST_APP: assert property (acc && REQ_LEVEL_I == 2'h0 |=>
        RSP_DENIED_O && !RSP_HIT_O && RSP_RDATA_O == 64'h0)
        else $error("application level not denied");
    AST_OS_MON: assert property (acc && REQ_LEVEL_I[0] |=> RSP_HIT_O && !RSP_DENIED_O)
        else $error("os or monitor access refused");
    AST_HYP: assert property (acc && REQ_LEVEL_I == 2'h2 |=>
        RSP_HIT_O == HAS_HYP && RSP_DENIED_O != HAS_HYP)
        else $error("hypervisor access wrong");
    AST_UNDEF: assert property (REQ_VALID_I && key && !HAS_PAUTH |=>
        RSP_UNDEF_O && !RSP_HIT_O && !RSP_DENIED_O)
        else $error("absent extension not undefined");
    AST_MISS: assert property (REQ_VALID_I && !key |=>
        !(RSP_HIT_O || RSP_DENIED_O || RSP_UNDEF_O))
        else $error("non key encoding flagged");
    AST_RAW: assert property (s_wr ##1 s_rd |=>
        RSP_RDATA_O == $past(REQ_WDATA_I, 2))
        else $error("read after write stale");
endmodule
bind pakr_key_regs pakr_key_regs_sva #(.HAS_PAUTH(HAS_PAUTH), .HAS_HYP(HAS_HYP)) chk_u (.*);

// File: sim/tb.sv
// testbench: writes, reads and refused accesses on the key register bank
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic valid = 1'b0;
    logic wr = 1'b0;
    logic [1:0] lvl = 2'h0;
    logic [15:0] enc = 16'h0;
    logic [63:0] wd = 64'h0;
    logic done, hit, undef, denied;
    logic [63:0] rd;
    logic done_b, hit_b, undef_b, denied_b, done_c, hit_c, undef_c, denied_c;
    logic [63:0] rd_b, rd_c;
    int err_total = 0;
    int num_checks = 0;
    logic [15:0] keys [5] = '{16'hC113, 16'hC112, 16'hC119, 16'hC118, 16'hC109};
    always #50 clk = ~clk;
    pakr_key_regs dut_u (.REF_CLK_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(valid), .REQ_WRITE_I(wr),
        .REQ_LEVEL_I(lvl), .REQ_ENC_I(enc), .REQ_WDATA_I(wd), .RSP_DONE_O(done), .RSP_HIT_O(hit),
        .RSP_UNDEF_O(undef), .RSP_DENIED_O(denied), .RSP_RDATA_O(rd));
    // the same requests reach a bank without the hypervisor level and one without the extension
    pakr_key_regs #(.HAS_PAUTH(1'h1), .HAS_HYP(1'h0)) dut_nohyp_u (.REF_CLK_I(clk),
        .RST_N_I(rst_n), .REQ_VALID_I(valid), .REQ_WRITE_I(wr), .REQ_LEVEL_I(lvl),
        .REQ_ENC_I(enc), .REQ_WDATA_I(wd), .RSP_DONE_O(done_b), .RSP_HIT_O(hit_b),
        .RSP_UNDEF_O(undef_b), .RSP_DENIED_O(denied_b), .RSP_RDATA_O(rd_b));
    pakr_key_regs #(.HAS_PAUTH(1'h0), .HAS_HYP(1'h1)) dut_nopa_u (.REF_CLK_I(clk),
        .RST_N_I(rst_n), .REQ_VALID_I(valid), .REQ_WRITE_I(wr), .REQ_LEVEL_I(lvl),
        .REQ_ENC_I(enc), .REQ_WDATA_I(wd), .RSP_DONE_O(done_c), .RSP_HIT_O(hit_c),
        .RSP_UNDEF_O(undef_c), .RSP_DENIED_O(denied_c), .RSP_RDATA_O(rd_c));
    // valid is left up so back-to-back calls issue one request per cycle
    task automatic acc(input logic w, input logic [1:0] l, input logic [15:0] e,
        input logic [63:0] d, input logic [3:0] f, input logic [63:0] r);
        valid = 1'b1;
        wr = w;
        lvl = l;
        enc = e;
        wd = d;
        @(negedge clk);
        `CHK({done, hit, undef, denied}, f)
        `CHK(rd, r)
        `CHK({done_b, hit_b, undef_b, denied_b}, (l == 2'h2 && f[2]) ? 4'h9 : f)
        `CHK(rd_b, (l == 2'h2) ? 64'h0 : r)
        `CHK({done_c, hit_c, undef_c, denied_c}, (f[2] || f[0]) ? 4'hA : 4'h8)
        `CHK(rd_c, 64'h0)
    endtask
    task automatic test_done;
        if (err_total == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [63:0] pat(input logic [15:0] e);
        return {e, ~e, e ^ 16'h5A5A, 16'hF00F};
    endfunction
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        `CHK(done, 1'b0)
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, 2'h1, keys[i], pat(keys[i]), 4'hC, 64'h0);
            acc(1'b0, 2'h3, keys[i], 64'h0, 4'hC, pat(keys[i]));
        end
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, 2'h2, keys[i], 64'h0, 4'hC, pat(keys[i]));
        end
        acc(1'b1, 2'h0, keys[0], 64'h0, 4'h9, 64'h0);
        acc(1'b0, 2'h0, keys[1], 64'h0, 4'h9, 64'h0);
        acc(1'b0, 2'h1, keys[0], 64'h0, 4'hC, pat(keys[0]));
        acc(1'b0, 2'h1, 16'hC10A, 64'h0, 4'h8, 64'h0);
        rst_n = 1'h0;
        wr = 1'h1;
        lvl = 2'h1;
        enc = keys[0];
        repeat (2) @(negedge clk);
        `CHK({done, done_b, done_c}, 3'h0)
        rst_n = 1'h1;
        acc(1'b0, 2'h3, keys[0], 64'h0, 4'hC, pat(keys[0]));
        valid = 1'b0;
        @(negedge clk);
        `CHK({done, hit}, 2'h0)
        test_done();
    end
endmodule
